// ==== core/card_status_map.svh ====
// card status word: bit positions, masks, state codes and reset value
// assumes nothing; included by the status package users by bare name
`ifndef CARD_STATUS_MAP_SVH
`define CARD_STATUS_MAP_SVH

`define CSW_ARG_RANGE_BIT      31
`define CSW_MISALIGN_BIT       30
`define CSW_BLK_LENGTH_BIT     29
`define CSW_ERASE_ORDER_BIT    28
`define CSW_ERASE_SEL_BIT      27
`define CSW_PROT_WRITE_BIT     26
`define CSW_LOCKED_BIT         25
`define CSW_UNLOCK_FAIL_BIT    24
`define CSW_CMD_CHECKSUM_BIT   23
`define CSW_ILLEGAL_BIT        22
`define CSW_ECC_FAIL_BIT       21
`define CSW_CTRL_INTERNAL_BIT  20
`define CSW_GENERAL_BIT        19
`define CSW_UNDERRUN_BIT       18
`define CSW_OVERRUN_BIT        17
`define CSW_ID_REWRITE_BIT     16
`define CSW_ERASE_SKIP_BIT     15
`define CSW_ECC_BYPASS_BIT     14
`define CSW_ERASE_CANCEL_BIT   13
`define CSW_STATE_HI           12
`define CSW_STATE_LO           9
`define CSW_BUF_EMPTY_BIT      8
`define CSW_EXPECTED_A_BIT     5

// clear-by-read, previous-command and card-following groups
`define CSW_CLR_READ_MASK      32'hFD3F_A020
`define CSW_CLR_PREV_MASK      32'h00C0_0000
`define CSW_FOLLOW_MASK        32'h0200_5F00
`define CSW_RESERVED_MASK      32'h0000_00DF

`define CSW_RESET_VALUE        32'h0000_0000

`define CSW_ST_IDLE            4'h0
`define CSW_ST_READY           4'h1
`define CSW_ST_IDENT           4'h2
`define CSW_ST_STBY            4'h3
`define CSW_ST_TRAN            4'h4
`define CSW_ST_DATA            4'h5
`define CSW_ST_RCV             4'h6
`define CSW_ST_PRG             4'h7
`define CSW_ST_DIS             4'h8

`endif

// ==== core/card_status_pkg.sv ====
// types shared by the card status word logic
// assumes the map header supplies all numeric constants
package card_status_pkg;

  // one-cycle event pulses from command decode and execution
  typedef struct packed {
    logic arg_range_err;
    logic addr_misalign_err;
    logic blk_length_err;
    logic erase_order_err;
    logic erase_selection_err;
    logic protected_write_err;
    logic unlock_fail_err;
    logic cmd_checksum_err;
    logic illegal_cmd_err;
    logic ecc_fail_err;
    logic controller_internal_err;
    logic general_err;
    logic stream_read_underrun;
    logic stream_write_overrun;
    logic id_reg_rewrite_err;
    logic erase_skip_flag;
    logic erase_cancel_flag;
    logic expected_a;
  } status_event_t;

  // card conditions that the word follows level for level
  typedef struct packed {
    logic       locked_flag;
    logic       ecc_bypass;
    logic       buf_empty;
    logic [3:0] card_state;
  } card_cond_t;

  typedef enum logic [0:0] {
    LINK_IDLE,
    LINK_WAIT
  } link_fsm_t;

endpackage

// ==== core/csw_toggle_sync.sv ====
// toggle synchroniser: turns a far-domain toggle into a local pulse
// assumes the toggle changes at most once per handshake round
`timescale 1ns/1ps
`default_nettype none

module csw_toggle_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic tog_in,
  output logic      pulse
);

  logic ff1_r;
  logic ff2_r;
  logic ff3_r;
  logic seen_r;

  // first flop only feeds the second; change counts once 2nd and 3rd agree
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ff1_r  <= 1'b0;
      ff2_r  <= 1'b0;
      ff3_r  <= 1'b0;
      seen_r <= 1'b0;
    end else begin
      ff1_r  <= tog_in;
      ff2_r  <= ff1_r;
      ff3_r  <= ff2_r;
      seen_r <= pulse ? ff3_r : seen_r;
    end
  end

  assign pulse = (ff2_r == ff3_r) && (ff3_r != seen_r);

endmodule

`default_nettype wire

// ==== core/card_status_word_logic.sv ====
// card status word register with its clearing disciplines and the
// crossing that hands a snapshot to the response framer on link_clk.
// assumes event pulses and card conditions arrive on core_clk from the
// command decoder; status requests arrive on link_clk from the framer.
`timescale 1ns/1ps
`default_nettype none
`include "card_status_map.svh"

// Overview of operation
// - argument arg_range_err sets bit 31, shown in that command's response.
// - address misaligned to block length sets bit 30.
// - bad block length or wrong byte count sets bit 29.
// - erase commands in wrong order set bit 28.
// - invalid erase selection found during execution sets bit 27.
// - write to a protected block sets bit 26.
// - bit 25 follows the lock state, never cleared by reading.
// - lock/unlock failure or access to locked card sets bit 24.
// - bit 23 flags failed command checksum, clears one valid command late.
// - bit 22 flags command illegal in state, cleared like bit 23.
// - uncorrectable internal error correction sets bit 21.
// - internal controller error sets bit 20; general error sets bit 19.
// - stream read underrun sets bit 18.
// - stream write overrun sets bit 17.
// - identification or card data register rewrite error sets bit 16.
// - erase partly skipped over protected blocks sets bit 15.
// - bit 14 follows whether error correction was bypassed.
// - erase sequence cancelled by foreign command sets bit 13.
// - bits 12 to 9 carry the card state code 0 to 8.
// - bit 8 mirrors the buffer-empty indication.
// - bit 5 shows an application command is expected or was taken.
// - a local 32-bit word is returned with each short response.
// - clear by read, by next valid command late, or by card state.
// - execution bits latch while running; host polls status to see them.
module card_status_word_logic (
  input  wire logic                          core_clk,
  input  wire logic                          resetn,
  input  wire logic                          link_clk,
  input  wire logic                          link_resetn,
  input  wire card_status_pkg::status_event_t events,
  input  wire logic                          cmd_valid,
  input  wire card_status_pkg::card_cond_t    cond,
  input  wire logic                          resp_req,
  output logic                               resp_ready,
  output logic [31:0]                        resp_status,
  output logic [31:0]                        status_word
);

  // ---------------------------------------------------------------
  // core domain
  // ---------------------------------------------------------------
  logic [31:0] status_r;
  logic [31:0] status_nxt;
  logic [31:0] shown_r;
  logic [31:0] shown_nxt;
  logic [31:0] snap_r;
  logic        ack_tog_r;
  logic        take_snap;
  logic [31:0] set_vec;
  logic [31:0] follow_vec;
  logic [31:0] clr_vec;
  logic [31:0] read_clr;
  logic [31:0] prev_clr;
  logic [31:0] follow_mask;
  logic [31:0] reserved_mask;
  logic [31:0] prev_mask;
  logic [31:0] read_mask;

  // link-side request crosses as a toggle
  logic req_tog_r;

  csw_toggle_sync u_req_sync (
    .clk    (core_clk),
    .rst_n  (resetn),
    .tog_in (req_tog_r),
    .pulse  (take_snap)
  );

  // event pulses mapped onto their word positions
  assign set_vec[`CSW_ARG_RANGE_BIT]     = events.arg_range_err;
  assign set_vec[`CSW_MISALIGN_BIT]      = events.addr_misalign_err;
  assign set_vec[`CSW_BLK_LENGTH_BIT]    = events.blk_length_err;
  assign set_vec[`CSW_ERASE_ORDER_BIT]   = events.erase_order_err;
  assign set_vec[`CSW_ERASE_SEL_BIT]     = events.erase_selection_err;
  assign set_vec[`CSW_PROT_WRITE_BIT]    = events.protected_write_err;
  assign set_vec[`CSW_LOCKED_BIT]        = 1'b0;
  assign set_vec[`CSW_UNLOCK_FAIL_BIT]   = events.unlock_fail_err;
  assign set_vec[`CSW_CMD_CHECKSUM_BIT]  = events.cmd_checksum_err;
  assign set_vec[`CSW_ILLEGAL_BIT]       = events.illegal_cmd_err;
  assign set_vec[`CSW_ECC_FAIL_BIT]      = events.ecc_fail_err;
  assign set_vec[`CSW_CTRL_INTERNAL_BIT] = events.controller_internal_err;
  assign set_vec[`CSW_GENERAL_BIT]       = events.general_err;
  assign set_vec[`CSW_UNDERRUN_BIT]      = events.stream_read_underrun;
  assign set_vec[`CSW_OVERRUN_BIT]       = events.stream_write_overrun;
  assign set_vec[`CSW_ID_REWRITE_BIT]    = events.id_reg_rewrite_err;
  assign set_vec[`CSW_ERASE_SKIP_BIT]    = events.erase_skip_flag;
  assign set_vec[`CSW_ECC_BYPASS_BIT]    = 1'b0;
  assign set_vec[`CSW_ERASE_CANCEL_BIT]  = events.erase_cancel_flag;
  assign set_vec[12:8]                   = 5'h00;
  assign set_vec[7:6]                    = 2'h0;
  assign set_vec[`CSW_EXPECTED_A_BIT]    = events.expected_a;
  assign set_vec[4:0]                    = 5'h00;

  // levels the word tracks directly, no latching
  assign follow_vec = {6'h00, cond.locked_flag, 10'h000, cond.ecc_bypass, 1'b0,
                       cond.card_state, cond.buf_empty, 8'h00};

  // a reported snapshot clears its clear-by-read bits
  assign read_clr = take_snap ? (status_r & `CSW_CLR_READ_MASK) : 32'h0000_0000;
  // a valid command clears previous-command bits already reported once
  assign prev_clr = cmd_valid ? (shown_r & `CSW_CLR_PREV_MASK) : 32'h0000_0000;
  assign clr_vec  = read_clr | prev_clr;

  // masks as named words so each slice picks one bit, no wide operand lands on a bit
  assign follow_mask   = `CSW_FOLLOW_MASK;
  assign reserved_mask = `CSW_RESERVED_MASK;
  assign prev_mask     = `CSW_CLR_PREV_MASK;
  assign read_mask     = `CSW_CLR_READ_MASK;

  // one slice per word bit; a fresh event beats a same-cycle clear
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi = gi + 1) begin : g_bit
      assign status_nxt[gi] = follow_mask[gi] ? follow_vec[gi]
                            : (reserved_mask[gi] ? 1'b0
                            : (set_vec[gi] | (status_r[gi] & ~clr_vec[gi])));
      assign shown_nxt[gi]  = (cmd_valid ? 1'b0 : shown_r[gi])
                            | (take_snap & status_r[gi] & prev_mask[gi]);
    end
  endgenerate

  // word, shown marks and the snapshot handed to the link side
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      status_r  <= `CSW_RESET_VALUE;
      shown_r   <= 32'h0000_0000;
      snap_r    <= `CSW_RESET_VALUE;
      ack_tog_r <= 1'b0;
    end else begin
      status_r  <= status_nxt;
      shown_r   <= shown_nxt;
      snap_r    <= take_snap ? status_r : snap_r;
      ack_tog_r <= ack_tog_r ^ take_snap;
    end
  end

  assign status_word = status_r;

  // ---------------------------------------------------------------
  // link domain: request a snapshot, wait for it, present it
  // ---------------------------------------------------------------
  card_status_pkg::link_fsm_t link_state_r;
  card_status_pkg::link_fsm_t link_state_nxt;
  logic                       ack_seen;
  logic [31:0]                resp_status_r;
  logic                       resp_ready_r;

  csw_toggle_sync u_ack_sync (
    .clk    (link_clk),
    .rst_n  (link_resetn),
    .tog_in (ack_tog_r),
    .pulse  (ack_seen)
  );

  // a request while one is in flight is dropped: one snapshot per response
  always_comb begin
    link_state_nxt = link_state_r;
    case (link_state_r)
      card_status_pkg::LINK_IDLE: begin
        if (resp_req) begin
          link_state_nxt = card_status_pkg::LINK_WAIT;
        end
      end
      card_status_pkg::LINK_WAIT: begin
        if (ack_seen) begin
          link_state_nxt = card_status_pkg::LINK_IDLE;
        end
      end
      default: begin
        link_state_nxt = card_status_pkg::LINK_IDLE;
      end
    endcase
  end

  wire link_start = (link_state_r == card_status_pkg::LINK_IDLE) && resp_req;
  wire link_done  = (link_state_r == card_status_pkg::LINK_WAIT) && ack_seen;

  // snap_r is frozen until the next request, so sampling it here is safe
  always_ff @(posedge link_clk) begin
    if (!link_resetn) begin
      link_state_r  <= card_status_pkg::LINK_IDLE;
      req_tog_r     <= 1'b0;
      resp_status_r <= `CSW_RESET_VALUE;
      resp_ready_r  <= 1'b0;
    end else begin
      link_state_r  <= link_state_nxt;
      req_tog_r     <= req_tog_r ^ link_start;
      resp_status_r <= link_done ? snap_r : resp_status_r;
      resp_ready_r  <= link_done;
    end
  end

  assign resp_status = resp_status_r;
  assign resp_ready  = resp_ready_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  reserved_zero_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (status_r & `CSW_RESERVED_MASK) == 32'h0000_0000)
    else $error("reserved status bits not zero");

  arg_range_set_a: assert property (@(posedge core_clk) disable iff (!resetn)
    events.arg_range_err |=> status_r[`CSW_ARG_RANGE_BIT])
    else $error("range error event not latched");

  misalign_hold_a: assert property (@(posedge core_clk) disable iff (!resetn)
    status_r[`CSW_MISALIGN_BIT] && !take_snap |=> status_r[`CSW_MISALIGN_BIT])
    else $error("misalign bit lost without a read");

  state_follow_a: assert property (@(posedge core_clk) disable iff (!resetn)
    ##1 status_r[`CSW_STATE_HI:`CSW_STATE_LO] == $past(cond.card_state))
    else $error("state field does not follow card state");

  lock_follow_a: assert property (@(posedge core_clk) disable iff (!resetn)
    take_snap && cond.locked_flag |=> status_r[`CSW_LOCKED_BIT])
    else $error("locked bit cleared by read");

  buf_ecc_follow_a: assert property (@(posedge core_clk) disable iff (!resetn)
    ##1 status_r[`CSW_BUF_EMPTY_BIT] == $past(cond.buf_empty)
        && status_r[`CSW_ECC_BYPASS_BIT] == $past(cond.ecc_bypass))
    else $error("buffer or bypass bit does not follow");

  checksum_late_a: assert property (@(posedge core_clk) disable iff (!resetn)
    events.cmd_checksum_err ##1 (cmd_valid && !take_snap && !events.cmd_checksum_err)
      |=> status_r[`CSW_CMD_CHECKSUM_BIT])
    else $error("checksum bit cleared before being reported");

  illegal_clear_a: assert property (@(posedge core_clk) disable iff (!resetn)
    shown_r[`CSW_ILLEGAL_BIT] && cmd_valid && !events.illegal_cmd_err
      |=> !status_r[`CSW_ILLEGAL_BIT])
    else $error("illegal bit not cleared by next valid command");

  read_clear_a: assert property (@(posedge core_clk) disable iff (!resetn)
    take_snap && status_r[`CSW_ECC_FAIL_BIT] && !events.ecc_fail_err
      |=> !status_r[`CSW_ECC_FAIL_BIT] && snap_r[`CSW_ECC_FAIL_BIT])
    else $error("read did not report then clear");

  snap_match_a: assert property (@(posedge core_clk) disable iff (!resetn)
    take_snap |=> snap_r == $past(status_r))
    else $error("snapshot differs from word");

  link_answer_a: assert property (@(posedge link_clk) disable iff (!link_resetn)
    link_start |-> ##[4:20] resp_ready)
    else $error("status answer not returned in time");

  blk_len_set_a: assert property (@(posedge core_clk) disable iff (!resetn)
    events.blk_length_err |=> status_r[`CSW_BLK_LENGTH_BIT])
    else $error("block length event not latched");

  erase_order_set_a: assert property (@(posedge core_clk) disable iff (!resetn)
    events.erase_order_err |=> status_r[`CSW_ERASE_ORDER_BIT])
    else $error("erase order event not latched");

  erase_sel_set_a: assert property (@(posedge core_clk) disable iff (!resetn)
    events.erase_selection_err |=> status_r[`CSW_ERASE_SEL_BIT])
    else $error("erase selection event not latched");

  prot_write_set_a: assert property (@(posedge core_clk) disable iff (!resetn)
    events.protected_write_err |=> status_r[`CSW_PROT_WRITE_BIT])
    else $error("protected write event not latched");

  unlock_fail_set_a: assert property (@(posedge core_clk) disable iff (!resetn)
    events.unlock_fail_err |=> status_r[`CSW_UNLOCK_FAIL_BIT])
    else $error("lock failure event not latched");

  ecc_fail_set_a: assert property (@(posedge core_clk) disable iff (!resetn)
    events.ecc_fail_err |=> status_r[`CSW_ECC_FAIL_BIT])
    else $error("correction failure event not latched");

  ctrl_err_set_a: assert property (@(posedge core_clk) disable iff (!resetn)
    events.controller_internal_err |=> status_r[`CSW_CTRL_INTERNAL_BIT])
    else $error("controller error event not latched");

  general_err_set_a: assert property (@(posedge core_clk) disable iff (!resetn)
    events.general_err |=> status_r[`CSW_GENERAL_BIT])
    else $error("general error event not latched");

  underrun_set_a: assert property (@(posedge core_clk) disable iff (!resetn)
    events.stream_read_underrun |=> status_r[`CSW_UNDERRUN_BIT])
    else $error("underrun event not latched");

  overrun_set_a: assert property (@(posedge core_clk) disable iff (!resetn)
    events.stream_write_overrun |=> status_r[`CSW_OVERRUN_BIT])
    else $error("overrun event not latched");

  id_rewrite_set_a: assert property (@(posedge core_clk) disable iff (!resetn)
    events.id_reg_rewrite_err |=> status_r[`CSW_ID_REWRITE_BIT])
    else $error("register rewrite event not latched");

  erase_skip_set_a: assert property (@(posedge core_clk) disable iff (!resetn)
    events.erase_skip_flag |=> status_r[`CSW_ERASE_SKIP_BIT])
    else $error("erase skip event not latched");

  erase_cancel_set_a: assert property (@(posedge core_clk) disable iff (!resetn)
    events.erase_cancel_flag |=> status_r[`CSW_ERASE_CANCEL_BIT])
    else $error("erase cancel event not latched");

  app_expect_set_a: assert property (@(posedge core_clk) disable iff (!resetn)
    events.expected_a |=> status_r[`CSW_EXPECTED_A_BIT])
    else $error("application command flag not latched");

  checksum_keep_a: assert property (@(posedge core_clk) disable iff (!resetn)
    status_r[`CSW_CMD_CHECKSUM_BIT] && !shown_r[`CSW_CMD_CHECKSUM_BIT] && cmd_valid
      |=> status_r[`CSW_CMD_CHECKSUM_BIT])
    else $error("checksum bit cleared before it was reported");

  illegal_keep_a: assert property (@(posedge core_clk) disable iff (!resetn)
    status_r[`CSW_ILLEGAL_BIT] && !shown_r[`CSW_ILLEGAL_BIT] && cmd_valid
      |=> status_r[`CSW_ILLEGAL_BIT])
    else $error("illegal bit cleared before it was reported");

  shown_prev_only_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (shown_r & ~prev_mask) == 32'h0000_0000)
    else $error("reported mark outside previous-command bits");

  read_clear_all_a: assert property (@(posedge core_clk) disable iff (!resetn)
    take_snap && set_vec == 32'h0000_0000 |=> (status_r & read_mask) == 32'h0000_0000)
    else $error("clear-by-read bit survived a read");

  snap_hold_a: assert property (@(posedge core_clk) disable iff (!resetn)
    !take_snap |=> $stable(snap_r))
    else $error("snapshot changed without a request");

  snap_pulse_a: assert property (@(posedge core_clk) disable iff (!resetn)
    take_snap |=> !take_snap)
    else $error("one request took two snapshots");

  ready_pulse_a: assert property (@(posedge link_clk) disable iff (!link_resetn)
    resp_ready |=> !resp_ready)
    else $error("answer strobe longer than one cycle");

  answer_hold_a: assert property (@(posedge link_clk) disable iff (!link_resetn)
    !resp_ready |-> $stable(resp_status))
    else $error("answer word changed without its strobe");

  busy_ignore_a: assert property (@(posedge link_clk) disable iff (!link_resetn)
    link_state_r == card_status_pkg::LINK_WAIT |=> $stable(req_tog_r))
    else $error("request in flight was not ignored");

endmodule

`default_nettype wire

// ==== testbench/status_poller.sv ====
// host-side poller model: asks for the status word over the link handshake
// assumes link_clk runs freely and that the bench calls read_status after reset
`timescale 1ns/1ps
`default_nettype none

module status_poller (
  input  wire logic        link_clk,
  output logic             resp_req,
  input  wire logic        resp_ready,
  input  wire logic [31:0] resp_status
);
  initial resp_req = 1'b0;

  // one request in flight; a second one would be ignored, so wait for the answer
  task automatic read_status(output logic [31:0] word, output bit ok);
    int n;
    ok = 1'b0;
    word = 32'h0;
    @(negedge link_clk);
    resp_req = 1'b1;
    @(negedge link_clk);
    resp_req = 1'b0;
    // strobe and word looked at mid-cycle, settled away from the edge that launches them
    for (n = 0; n < 40 && !ok; n++) begin
      @(negedge link_clk);
      if (resp_ready === 1'b1) begin
        word = resp_status;
        ok = 1'b1;
      end
    end
  endtask
endmodule
`default_nettype wire

// ==== testbench/card_status_word_logic_tb.sv ====
// self-checking bench for the card status word logic
// assumes the design package and map header are compiled first
`timescale 1ns/1ps
`default_nettype none

module card_status_word_logic_tb;
  logic                           core_clk;
  logic                           link_clk;
  logic                           resetn;
  logic                           link_resetn;
  logic                           cmd_valid;
  logic                           resp_req;
  logic                           resp_ready;
  card_status_pkg::status_event_t events;
  card_status_pkg::card_cond_t    cond;
  logic [31:0]                    resp_status;
  logic [31:0]                    status_word;
  logic [31:0]                    w;
  bit                             ok;
  int                             error_cnt;
  int                             cmp_count;
  int                             pos [18] = '{31, 30, 29, 28, 27, 26, 24, 23, 22, 21, 20, 19, 18, 17, 16, 15, 13, 5};

  initial core_clk = 1'b0;
  always #2.5 core_clk = ~core_clk;
  // link edges sit 1.3 ns off the core grid so the domains never share an edge
  initial link_clk = 1'b0;
  always begin
    #1.3;
    forever #7.5 link_clk = ~link_clk;
  end

  card_status_word_logic dut (
    .core_clk    (core_clk),
    .resetn      (resetn),
    .link_clk    (link_clk),
    .link_resetn (link_resetn),
    .events      (events),
    .cmd_valid   (cmd_valid),
    .cond        (cond),
    .resp_req    (resp_req),
    .resp_ready  (resp_ready),
    .resp_status (resp_status),
    .status_word (status_word)
  );

  status_poller poll (
    .link_clk    (link_clk),
    .resp_req    (resp_req),
    .resp_ready  (resp_ready),
    .resp_status (resp_status)
  );

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // a read that never gets its ready pulse counts as a mismatch
  task automatic poll_status;
    poll.read_status(w, ok);
    if (!ok) begin
      error_cnt++;
      $display("CHECK FAILED resp_ready expected 1 seen 0");
    end
    repeat (3) @(negedge core_clk);
  endtask

  task automatic pulse_cmd;
    cmd_valid = 1'b1;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    @(negedge core_clk);
  endtask

  initial begin
    resetn = 1'b0;
    link_resetn = 1'b0;
    cmd_valid = 1'b0;
    events = '0;
    cond = '0;
    error_cnt = 0;
    cmp_count = 0;
    // the link reset needs edges of its own clock, so both are held longer
    repeat (3) @(negedge link_clk);
    @(negedge core_clk);
    resetn = 1'b1;
    link_resetn = 1'b1;
    @(negedge core_clk);
    check("status_word", status_word, 32'h0);
    // each event alone: set, reported once, then cleared its own way
    for (int i = 0; i < 18; i++) begin
      events = card_status_pkg::status_event_t'(18'h1 << (17 - i));
      @(negedge core_clk);
      events = '0;
      @(negedge core_clk);
      check("status_word", status_word, 32'h1 << pos[i]);
      // a command before any report must not clear the previous-command bits
      if (pos[i] == 23 || pos[i] == 22) begin
        pulse_cmd();
        check("status_word", status_word, 32'h1 << pos[i]);
      end
      poll_status();
      check("resp_status", w, 32'h1 << pos[i]);
      if (pos[i] == 23 || pos[i] == 22) begin
        check("status_word", status_word, 32'h1 << pos[i]);
        pulse_cmd();
      end
      check("status_word", status_word, 32'h0);
    end
    // all events in one cycle, reserved positions stay zero
    events = '1;
    @(negedge core_clk);
    events = '0;
    @(negedge core_clk);
    check("status_word", status_word, 32'hFDFF_A020);
    check("reserved", status_word & 32'h0000_00DF, 32'h0);
    poll_status();
    check("resp_status", w, 32'hFDFF_A020);
    pulse_cmd();
    check("status_word", status_word, 32'h0);
    // following bits track the card conditions and survive a read
    for (int s = 0; s < 9; s++) begin
      logic [31:0] exp;
      exp = {6'h0, s[0], 10'h0, s[1], 1'b0, s[3:0], ~s[0], 8'h0};
      cond = card_status_pkg::card_cond_t'({s[0], s[1], ~s[0], s[3:0]});
      @(negedge core_clk);
      check("status_word", status_word, exp);
      poll_status();
      check("resp_status", w, exp);
      check("status_word", status_word, exp);
    end
    // second reset in mid-run wipes latched bits and the held answer
    events = '1;
    @(negedge core_clk);
    events = '0;
    cond = '0;
    resetn = 1'b0;
    link_resetn = 1'b0;
    repeat (3) @(negedge link_clk);
    @(negedge core_clk);
    resetn = 1'b1;
    link_resetn = 1'b1;
    @(negedge core_clk);
    check("status_word", status_word, 32'h0);
    check("resp_status", resp_status, 32'h0);
    poll_status();
    check("resp_status", w, 32'h0);
    end_of_test();
  end

  // the whole sequence needs well under 20 us
  initial begin
    #60000;
    error_cnt++;
    $display("CHECK FAILED watchdog expected done seen timeout");
    end_of_test();
  end
endmodule
`default_nettype wire
